// ==== hw/lsi_top.sv ====
// lamp status indicator: power, traffic and info lamps with axi4-lite control
`timescale 1ns/100ps
module lsi_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // axi4-lite write address
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [7:0] awaddr_in,
  // axi4-lite write data
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  // axi4-lite write response
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // axi4-lite read address
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [7:0] araddr_in,
  // axi4-lite read data
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  // unit status
  input wire logic configured_in,
  input wire logic cfg_error_in,
  input wire logic power_low_in,
  input wire logic fw_update_in,
  // channel status
  input wire lsi_pkg::lsi_ch_t [lsi_pkg::NUM_CH-1:0] ch_in,
  // lamps: c0 green, c1 yellow for power and info; c0 yellow, c1 red for traffic
  output lsi_pkg::lsi_lamp_t power_lamp_out,
  output lsi_pkg::lsi_lamp_t [lsi_pkg::NUM_CH-1:0] channel_traffic_lamp_out,
  output lsi_pkg::lsi_lamp_t [lsi_pkg::NUM_CH-1:0] info_lamp_out
);

  // --------------------------------------------------------------------
  // pattern decode, used for the power and traffic lamps
  // --------------------------------------------------------------------
  function automatic lsi_pkg::lsi_lamp_t pat_drive(input lsi_pkg::lsi_pat_t p,
      input logic col, input logic sph, input logic fph);
    lsi_pkg::lsi_lamp_t l;
    logic on;
    l = '0;
    on = 1'b0;
    unique case (p)
      lsi_pkg::LSI_OFF: on = 1'b0;
      lsi_pkg::LSI_ON: on = 1'b1;
      lsi_pkg::LSI_SBLINK: on = sph;
      lsi_pkg::LSI_FBLINK: on = fph;
      lsi_pkg::LSI_SWAVER: on = sph;
      lsi_pkg::LSI_FWAVER: on = fph;
      default: on = 1'b0;
    endcase
    if (col) l.c1 = on;
    else l.c0 = on;
    // waver lights the other colour in the dark half
    if (p == lsi_pkg::LSI_SWAVER || p == lsi_pkg::LSI_FWAVER) begin
      if (col) l.c0 = ~on;
      else l.c1 = ~on;
    end
    return l;
  endfunction : pat_drive

  // --------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------
  logic [1:0] ctrl_r, ctrl_nxt; // run and device error bits
  logic [lsi_pkg::CNT_W-1:0] flash_r, flash_nxt; // flash length
  logic [lsi_pkg::CNT_W-1:0] slow_r, slow_nxt; // slow half period
  logic [lsi_pkg::CNT_W-1:0] fast_r, fast_nxt; // fast half period

  // --------------------------------------------------------------------
  // bus slave state
  // --------------------------------------------------------------------
  logic aw_hold_r, aw_hold_nxt; // write address captured
  logic w_hold_r, w_hold_nxt; // write data captured
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_write; // both halves present, response channel free

  // --------------------------------------------------------------------
  // lamp state
  // --------------------------------------------------------------------
  logic slow_ph, fast_ph; // blink phases
  logic [lsi_pkg::NUM_CH-1:0] yflash, rflash, ovr; // per channel conditioned state
  logic [3:0] run_idx_r, run_idx_nxt; // running step
  logic [lsi_pkg::CNT_W-1:0] run_cnt_r, run_cnt_nxt; // running step timer
  lsi_pkg::lsi_lamp_t pwr_r, pwr_nxt;
  lsi_pkg::lsi_lamp_t [lsi_pkg::NUM_CH-1:0] trf_r, trf_nxt;
  lsi_pkg::lsi_lamp_t [lsi_pkg::NUM_CH-1:0] inf_r, inf_nxt;

  // --------------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------------
  lsi_timebase u_tb (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .slow_half_in(slow_r),
    .fast_half_in(fast_r),
    .slow_ph_out(slow_ph),
    .fast_ph_out(fast_ph)
  );

  genvar gi;
  generate
    for (gi = 0; gi < lsi_pkg::NUM_CH; gi++) begin : g_ch
      lsi_chan u_ch (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .st_in(ch_in[gi]),
        .flash_len_in(flash_r),
        .yel_flash_out(yflash[gi]),
        .red_flash_out(rflash[gi]),
        .overrun_out(ovr[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // bus slave: address and data taken in either order, one at a time
  // --------------------------------------------------------------------
  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    flash_nxt = flash_r;
    slow_nxt = slow_r;
    fast_nxt = fast_r;
    // capture halves of a write
    if (awvalid_in && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = awaddr_in;
    end
    if (wvalid_in && !w_hold_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = wdata_in;
      wstrb_nxt = wstrb_in;
    end
    // perform write; only full-word writes of the low bytes matter here
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = lsi_pkg::RESP_OKAY;
      unique case (awaddr_r)
        lsi_pkg::REG_CTRL: if (wstrb_r[0]) ctrl_nxt = wdata_r[1:0];
        lsi_pkg::REG_FLASH: flash_nxt = wdata_r[lsi_pkg::CNT_W-1:0];
        lsi_pkg::REG_SLOW: slow_nxt = wdata_r[lsi_pkg::CNT_W-1:0];
        lsi_pkg::REG_FAST: fast_nxt = wdata_r[lsi_pkg::CNT_W-1:0];
        default: bresp_nxt = lsi_pkg::RESP_SLVERR; // unmapped or read only
      endcase
    end
    if (bvalid_r && bready_in) bvalid_nxt = 1'b0;
    // reads answer one cycle after the address is taken
    if (rvalid_r && rready_in) rvalid_nxt = 1'b0;
    if (arvalid_in && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = lsi_pkg::RESP_OKAY;
      rdata_nxt = '0;
      unique case (araddr_in)
        lsi_pkg::REG_CTRL: rdata_nxt = {30'h0, ctrl_r};
        lsi_pkg::REG_FLASH: rdata_nxt = {8'h00, flash_r};
        lsi_pkg::REG_SLOW: rdata_nxt = {8'h00, slow_r};
        lsi_pkg::REG_FAST: rdata_nxt = {8'h00, fast_r};
        lsi_pkg::REG_STAT: rdata_nxt = {20'h0, pwr_r, trf_r, inf_r, 2'h0};
        default: rresp_nxt = lsi_pkg::RESP_SLVERR;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // lamp selection, highest priority last
  // --------------------------------------------------------------------
  always_comb begin
    run_cnt_nxt = run_cnt_r + 24'h000001;
    run_idx_nxt = run_idx_r;
    if (!ctrl_r[lsi_pkg::CTRL_RUN]) begin
      run_cnt_nxt = '0;
      run_idx_nxt = '0;
    end else if (run_cnt_nxt >= lsi_pkg::RUN_STEP_DEF) begin
      run_cnt_nxt = '0;
      run_idx_nxt = (run_idx_r == lsi_pkg::RUN_LAST) ? 4'h0 : run_idx_r + 4'h1;
    end
    // power lamp
    if (!configured_in)
      pwr_nxt = pat_drive(lsi_pkg::LSI_SBLINK, 1'b1, slow_ph, fast_ph);
    else if (cfg_error_in || power_low_in)
      pwr_nxt = pat_drive(lsi_pkg::LSI_SWAVER, 1'b0, slow_ph, fast_ph);
    else
      pwr_nxt = pat_drive(lsi_pkg::LSI_ON, 1'b0, slow_ph, fast_ph);
    for (int i = 0; i < lsi_pkg::NUM_CH; i++) begin
      // info lamp shows lin use and reference voltage
      inf_nxt[i].c0 = ch_in[i].lin_mode;
      inf_nxt[i].c1 = ch_in[i].lin_vref;
      // traffic lamp, channel activity first
      trf_nxt[i] = '0;
      trf_nxt[i].c0 = yflash[i];
      if (!ch_in[i].lin_mode) begin
        if (ch_in[i].err_passive)
          trf_nxt[i] = pat_drive(lsi_pkg::LSI_FBLINK, 1'b1, slow_ph, fast_ph);
        if (rflash[i]) trf_nxt[i].c1 = 1'b1;
        if (ovr[i]) trf_nxt[i] = pat_drive(lsi_pkg::LSI_ON, 1'b1, slow_ph, fast_ph);
      end
      // unit wide conditions override the channel
      if (fw_update_in)
        trf_nxt[i] = pat_drive(lsi_pkg::LSI_FBLINK, 1'b0, slow_ph, fast_ph);
      if (ctrl_r[lsi_pkg::CTRL_DEVERR]) trf_nxt[i] = 2'b10;
      if (power_low_in)
        trf_nxt[i] = pat_drive(lsi_pkg::LSI_SBLINK, 1'b0, slow_ph, fast_ph);
      if (cfg_error_in)
        trf_nxt[i] = pat_drive(lsi_pkg::LSI_SWAVER, 1'b0, slow_ph, fast_ph);
      if (!configured_in) trf_nxt[i] = '0;
    end
    // running self display takes every lamp
    if (ctrl_r[lsi_pkg::CTRL_RUN]) begin
      pwr_nxt = {run_idx_r == 4'h1, run_idx_r == 4'h0};
      for (int i = 0; i < lsi_pkg::NUM_CH; i++) begin
        trf_nxt[i] = {run_idx_r == 4'(2 + 2 * i + 1), run_idx_r == 4'(2 + 2 * i)};
        inf_nxt[i] = {run_idx_r == 4'(6 + 2 * i + 1), run_idx_r == 4'(6 + 2 * i)};
      end
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r <= '0;
      flash_r <= lsi_pkg::FLASH_CYC_DEF;
      slow_r <= lsi_pkg::SLOW_HALF_DEF;
      fast_r <= lsi_pkg::FAST_HALF_DEF;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= '0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= '0;
      run_idx_r <= '0;
      run_cnt_r <= '0;
      pwr_r <= '0;
      trf_r <= '0;
      inf_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      flash_r <= flash_nxt;
      slow_r <= slow_nxt;
      fast_r <= fast_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      run_idx_r <= run_idx_nxt;
      run_cnt_r <= run_cnt_nxt;
      pwr_r <= pwr_nxt;
      trf_r <= trf_nxt;
      inf_r <= inf_nxt;
    end
  end

  // write ready flags are the inverse of the hold flops, read ready the inverse of rvalid_r
  always_comb begin
    awready_out = !aw_hold_r;
    wready_out = !w_hold_r;
    arready_out = !rvalid_r;
  end
  assign bvalid_out = bvalid_r;
  assign bresp_out = bresp_r;
  assign rvalid_out = rvalid_r;
  assign rdata_out = rdata_r;
  assign rresp_out = rresp_r;
  assign power_lamp_out = pwr_r;
  assign channel_traffic_lamp_out = trf_r;
  assign info_lamp_out = inf_r;

endmodule : lsi_top

// ==== hw/lsi_pkg.sv ====
// package for the lamp status indicator: patterns, colours, timing, register map
package lsi_pkg;

  // --------------------------------------------------------------------
  // channels and timing
  // --------------------------------------------------------------------
  localparam int NUM_CH = 2; // two channel lamps of each kind
  localparam int CNT_W = 24; // width of the pattern timers
  localparam logic [CNT_W-1:0] FLASH_CYC_DEF = 24'h030D40; // flash length, 8 ms at 25 MHz
  localparam logic [CNT_W-1:0] SLOW_HALF_DEF = 24'h2FAF08; // slow half period, 125 ms
  localparam logic [CNT_W-1:0] FAST_HALF_DEF = 24'h0BEBC2; // fast half period, 31.25 ms
  localparam logic [CNT_W-1:0] RUN_STEP_DEF = 24'h2FAF08; // running step length

  // --------------------------------------------------------------------
  // register map, byte addresses
  // --------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // control bits
  localparam logic [7:0] REG_FLASH = 8'h04; // flash length
  localparam logic [7:0] REG_SLOW = 8'h08; // slow half period
  localparam logic [7:0] REG_FAST = 8'h0C; // fast half period
  localparam logic [7:0] REG_STAT = 8'h10; // lamp state readback
  localparam int CTRL_RUN = 0; // running self-display enable
  localparam int CTRL_DEVERR = 1; // device error indication
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------------
  // lamp patterns and colours
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    LSI_OFF = 3'h0, LSI_ON = 3'h1, LSI_SBLINK = 3'h2, LSI_FBLINK = 3'h3,
    LSI_SWAVER = 3'h4, LSI_FWAVER = 3'h5
  } lsi_pat_t;

  // dual colour lamp drive: c0 first colour, c1 second colour
  typedef struct packed {
    logic c1;
    logic c0;
  } lsi_lamp_t;

  // per channel status inputs
  typedef struct packed {
    logic lin_mode; // channel opened as lin
    logic lin_vref; // lin reference voltage present
    logic msg_evt; // frame sent/received or internal activity, pulse
    logic err_evt; // error frame received, pulse
    logic err_passive; // error passive level
    logic overrun_evt; // receive overrun, pulse
    logic bus_off; // bus off level
  } lsi_ch_t;

  // --------------------------------------------------------------------
  // running sequence length
  // --------------------------------------------------------------------
  localparam int RUN_LEN = 2 + 4 * NUM_CH; // every colour of every lamp
  localparam logic [3:0] RUN_LAST = 4'h9; // last step index

endpackage : lsi_pkg

// ==== hw/lsi_timebase.sv ====
// free running phase generator for slow and fast blink
`timescale 1ns/100ps
module lsi_timebase (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // half periods in cycles
  input wire logic [lsi_pkg::CNT_W-1:0] slow_half_in,
  input wire logic [lsi_pkg::CNT_W-1:0] fast_half_in,
  // phases
  output logic slow_ph_out,
  output logic fast_ph_out
);

  // --------------------------------------------------------------------
  // counters, one per rate
  // --------------------------------------------------------------------
  logic [lsi_pkg::CNT_W-1:0] slow_cnt_r, slow_cnt_nxt; // slow phase timer
  logic [lsi_pkg::CNT_W-1:0] fast_cnt_r, fast_cnt_nxt; // fast phase timer
  logic slow_ph_r, slow_ph_nxt; // slow phase, equal on and off halves
  logic fast_ph_r, fast_ph_nxt; // fast phase, equal on and off halves

  // next values; a half of zero is treated as one cycle
  always_comb begin
    slow_cnt_nxt = slow_cnt_r + 24'h000001;
    slow_ph_nxt = slow_ph_r;
    if (slow_cnt_nxt >= slow_half_in) begin
      slow_cnt_nxt = '0;
      slow_ph_nxt = ~slow_ph_r;
    end
    fast_cnt_nxt = fast_cnt_r + 24'h000001;
    fast_ph_nxt = fast_ph_r;
    if (fast_cnt_nxt >= fast_half_in) begin
      fast_cnt_nxt = '0;
      fast_ph_nxt = ~fast_ph_r;
    end
  end

  // registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slow_cnt_r <= '0;
      fast_cnt_r <= '0;
      slow_ph_r <= 1'b0;
      fast_ph_r <= 1'b0;
    end else begin
      slow_cnt_r <= slow_cnt_nxt;
      fast_cnt_r <= fast_cnt_nxt;
      slow_ph_r <= slow_ph_nxt;
      fast_ph_r <= fast_ph_nxt;
    end
  end

  assign slow_ph_out = slow_ph_r;
  assign fast_ph_out = fast_ph_r;

endmodule : lsi_timebase

// ==== hw/lsi_chan.sv ====
// one channel: flash stretchers and overrun latch for the traffic lamp
`timescale 1ns/100ps
module lsi_chan (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // status and flash length
  input wire lsi_pkg::lsi_ch_t st_in,
  input wire logic [lsi_pkg::CNT_W-1:0] flash_len_in,
  // conditioned state
  output logic yel_flash_out,
  output logic red_flash_out,
  output logic overrun_out
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [lsi_pkg::CNT_W-1:0] ycnt_r, ycnt_nxt; // yellow flash remaining
  logic [lsi_pkg::CNT_W-1:0] rcnt_r, rcnt_nxt; // red flash remaining
  logic ovr_r, ovr_nxt; // overrun latched

  // retrigger reloads, so back to back events look steady
  always_comb begin
    ycnt_nxt = (ycnt_r != '0) ? ycnt_r - 24'h000001 : ycnt_r;
    rcnt_nxt = (rcnt_r != '0) ? rcnt_r - 24'h000001 : rcnt_r;
    if (st_in.msg_evt) ycnt_nxt = flash_len_in;
    if (st_in.err_evt && !st_in.lin_mode) rcnt_nxt = flash_len_in;
    ovr_nxt = ovr_r;
    if (st_in.bus_off || st_in.lin_mode) ovr_nxt = 1'b0;
    // a new overrun wins over the bus-off clear in the same cycle
    if (st_in.overrun_evt && !st_in.lin_mode) ovr_nxt = 1'b1;
  end

  // registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ycnt_r <= '0;
      rcnt_r <= '0;
      ovr_r <= 1'b0;
    end else begin
      ycnt_r <= ycnt_nxt;
      rcnt_r <= rcnt_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  assign yel_flash_out = (ycnt_r != '0);
  assign red_flash_out = (rcnt_r != '0);
  assign overrun_out = ovr_r;

endmodule : lsi_chan

// ==== tb/lsi_props.sv ====
// assertion checker for the lamp status indicator ports
`timescale 1ns/100ps
module lsi_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // register bus
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic [7:0] awaddr_in,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic [1:0] bresp_out,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [7:0] araddr_in,
  input wire logic rvalid_out,
  input wire logic [1:0] rresp_out,
  // unit status
  input wire logic configured_in,
  input wire logic cfg_error_in,
  input wire logic power_low_in,
  input wire logic fw_update_in,
  input wire lsi_pkg::lsi_ch_t [lsi_pkg::NUM_CH-1:0] ch_in,
  // lamps
  input wire lsi_pkg::lsi_lamp_t power_lamp_out,
  input wire lsi_pkg::lsi_lamp_t [lsi_pkg::NUM_CH-1:0] channel_traffic_lamp_out,
  input wire lsi_pkg::lsi_lamp_t [lsi_pkg::NUM_CH-1:0] info_lamp_out
);
  // --------------------------------------------------------------------
  // shadow of the control word
  // --------------------------------------------------------------------
  logic [1:0] ctrl_r; // run and device error bits
  logic [1:0] ctrl_nxt;
  logic ctrl_wr; // assumes both write halves are taken together
  logic quiet; // no override active
  assign ctrl_wr = awvalid_in && awready_out && wvalid_in && wready_out
    && awaddr_in == lsi_pkg::REG_CTRL && wstrb_in[0];
  assign quiet = ctrl_r == 2'h0;
  // next shadow value
  always_comb begin
    ctrl_nxt = ctrl_wr ? wdata_in[1:0] : ctrl_r;
  end
  // shadow register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r <= 2'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  // --------------------------------------------------------------------
  // properties; five stable cycles cover the lamp pipeline
  // --------------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  b_hold_a: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("write response dropped early");
  r_slverr_a: assert property (arvalid_in && arready_out && araddr_in > 8'h10
    |=> rvalid_out && rresp_out == lsi_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  unconf_off_a: assert property ((!configured_in && quiet) [*5]
    |-> channel_traffic_lamp_out == 4'h0 && !power_lamp_out.c0) else $error("unconfigured lamps");
  pwr_green_a: assert property ((configured_in && !cfg_error_in && !power_low_in
    && !ctrl_r[0]) [*5] |-> power_lamp_out == 2'h1) else $error("power lamp not steady green");
  cfg_waver_a: assert property ((configured_in && cfg_error_in && quiet) [*5]
    |-> power_lamp_out.c0 != power_lamp_out.c1
    && channel_traffic_lamp_out[0].c0 != channel_traffic_lamp_out[0].c1) else $error("no waver");
  plow_yel_a: assert property ((configured_in && !cfg_error_in && power_low_in && quiet)
    [*5] |-> power_lamp_out.c0 != power_lamp_out.c1 && channel_traffic_lamp_out[0].c1 == 1'b0
    && channel_traffic_lamp_out[0] == channel_traffic_lamp_out[1])
    else $error("power problem pattern wrong");
  fw_same_a: assert property ((configured_in && !cfg_error_in && !power_low_in
    && fw_update_in && quiet) [*5] |-> channel_traffic_lamp_out[0] == channel_traffic_lamp_out[1]
    && !channel_traffic_lamp_out[0].c1) else $error("update lamps not together");
  dev_red_a: assert property ((configured_in && !cfg_error_in && !power_low_in
    && ctrl_r == 2'h2) [*5] |-> channel_traffic_lamp_out == 4'hA)
    else $error("device error reds missing");
  info_lin_a: assert property ((!ctrl_r[0] && $stable(ch_in[1].lin_mode)) [*5]
    |-> info_lamp_out[1].c0 == ch_in[1].lin_mode) else $error("info green wrong");
  run_one_a: assert property (ctrl_r[0] [*5]
    |-> $onehot({power_lamp_out, channel_traffic_lamp_out, info_lamp_out}))
    else $error("running lights more than one colour");
endmodule : lsi_props

bind lsi_top lsi_props lsi_props_inst (.*);

// ==== tb/lsi_src.sv ====
// channel status source model: levels and single cycle event strobes
`timescale 1ns/100ps
module lsi_src (
  // clock
  input wire logic clk_in,
  // status towards the indicator
  output lsi_pkg::lsi_ch_t [lsi_pkg::NUM_CH-1:0] ch_out
);
  // --------------------------------------------------------------------
  // status state
  // --------------------------------------------------------------------
  lsi_pkg::lsi_ch_t [lsi_pkg::NUM_CH-1:0] st_r = '0; // levels and strobes
  assign ch_out = st_r;
  // level change, seen from the next edge
  task automatic set_lvl(input int c, input int f, input logic v);
    st_r[c][f] <= v;
  endtask : set_lvl
  // events last exactly one cycle, as a controller strobes them
  task automatic pulse(input int c, input int f);
    st_r[c][f] <= 1'b1;
    @(posedge clk_in);
    st_r[c][f] <= 1'b0;
  endtask : pulse
endmodule : lsi_src

// ==== tb/lsi_top_bench.sv ====
// self-checking bench for the lamp status indicator
`timescale 1ns/100ps
module lsi_top_bench;
  // --------------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------------
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic awvalid_in = 1'b0;
  logic [7:0] awaddr_in = 8'h00;
  logic wvalid_in = 1'b0;
  logic [31:0] wdata_in = 32'h0;
  logic [3:0] wstrb_in = 4'hF; // full words only
  logic bready_in = 1'b0;
  logic arvalid_in = 1'b0;
  logic [7:0] araddr_in = 8'h00;
  logic rready_in = 1'b0;
  logic configured_in = 1'b0;
  logic cfg_error_in = 1'b0;
  logic power_low_in = 1'b0;
  logic fw_update_in = 1'b0;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out;
  logic [31:0] rdata_out;
  lsi_pkg::lsi_ch_t [lsi_pkg::NUM_CH-1:0] ch_in;
  lsi_pkg::lsi_lamp_t power_lamp_out;
  lsi_pkg::lsi_lamp_t [lsi_pkg::NUM_CH-1:0] channel_traffic_lamp_out, info_lamp_out;
  logic [9:0] lamps; // 9 pwr y, 8 pwr g, 7:4 traffic {red,yel}, 3:0 info {yel,grn}
  int mismatches = 0;
  int num_checks = 0;
  localparam int F_LIN = 6, F_VREF = 5, F_MSG = 4, F_ERR = 3, F_EP = 2, F_OVR = 1,
    F_BOFF = 0; // status field positions
  assign lamps = {power_lamp_out, channel_traffic_lamp_out, info_lamp_out};
  lsi_top lsi_top_inst (.*);
  lsi_src lsi_src_inst (.clk_in(clk_in), .ch_out(ch_in));
  // 25 MHz clock
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid_in && awready_out) awvalid_in <= 1'b0;
      if (wvalid_in && wready_out) wvalid_in <= 1'b0;
    end while (!bvalid_out);
    r = bresp_out;
    bready_in <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid_in && arready_out) arvalid_in <= 1'b0;
    end while (!rvalid_out);
    d = rdata_out;
    r = rresp_out;
    rready_in <= 1'b0;
    tick(1);
  endtask : rd
  // 40 samples of one lamp bit: lit count and number of changes
  task automatic mchk(input int b, input int eon, input int etg);
    int on = 0, tg = 0;
    logic p;
    p = lamps[b];
    repeat (40) begin
      @(posedge clk_in);
      on += lamps[b];
      tg += (lamps[b] != p);
      p = lamps[b];
    end
    chk(on, eon);
    chk(tg, etg);
  endtask : mchk
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(lsi_pkg::REG_SLOW, d, r);
    chk(d, 32'h002FAF08);
    rd(lsi_pkg::REG_FAST, d, r);
    chk(d, 32'h000BEBC2);
    wr(lsi_pkg::REG_FLASH, 32'h3, r);
    wr(lsi_pkg::REG_SLOW, 32'h4, r);
    wr(lsi_pkg::REG_FAST, 32'h2, r);
    rd(lsi_pkg::REG_FLASH, d, r);
    chk(d, 32'h3);
    wr(lsi_pkg::REG_STAT, 32'hFFF, r); // read-only place is refused
    chk(r, lsi_pkg::RESP_SLVERR);
    rd(8'h20, d, r);
    chk(r, lsi_pkg::RESP_SLVERR);
  endtask : t_regs
  // unconfigured, then normal, then channel events in can mode
  task automatic t_can();
    mchk(9, 20, 10);
    lsi_src_inst.pulse(0, F_MSG);
    mchk(4, 0, 0);
    configured_in <= 1'b1;
    tick(4);
    mchk(8, 40, 0);
    lsi_src_inst.pulse(0, F_MSG);
    mchk(4, 3, 2);
    for (int k = 0; k < 4; k++) begin
      lsi_src_inst.pulse(0, F_MSG);
      tick(1);
      if (k > 0) chk(lamps[4], 1'b1);
    end
    tick(6);
    lsi_src_inst.pulse(0, F_ERR);
    mchk(5, 3, 2);
    lsi_src_inst.set_lvl(0, F_EP, 1'b1);
    tick(4);
    mchk(5, 20, 20);
    lsi_src_inst.set_lvl(0, F_EP, 1'b0);
    lsi_src_inst.pulse(1, F_OVR);
    tick(3);
    mchk(7, 40, 0);
    lsi_src_inst.set_lvl(1, F_BOFF, 1'b1);
    tick(4);
    chk(lamps[7], 1'b0);
    lsi_src_inst.set_lvl(1, F_BOFF, 1'b0);
  endtask : t_can
  task automatic t_lin();
    lsi_src_inst.set_lvl(1, F_LIN, 1'b1);
    lsi_src_inst.set_lvl(1, F_VREF, 1'b1);
    tick(4);
    chk(lamps[3:2], 2'h3);
    lsi_src_inst.set_lvl(1, F_VREF, 1'b0);
    tick(4);
    chk(lamps[3:2], 2'h1);
    lsi_src_inst.pulse(1, F_MSG);
    mchk(6, 3, 2);
    lsi_src_inst.set_lvl(1, F_LIN, 1'b0);
  endtask : t_lin
  // software overrides: device error and running display
  task automatic t_ctrl();
    logic [1:0] r;
    logic [31:0] d;
    wr(lsi_pkg::REG_CTRL, 32'h2, r);
    tick(4);
    chk(lamps[7:4], 4'hA);
    wr(lsi_pkg::REG_CTRL, 32'h1, r);
    tick(4);
    chk(lamps, 10'h100);
    rd(lsi_pkg::REG_STAT, d, r);
    chk(d, 32'h400);
    wr(lsi_pkg::REG_CTRL, 32'h0, r);
  endtask : t_ctrl
  // unit level conditions, each in turn
  task automatic t_unit();
    fw_update_in <= 1'b1;
    tick(4);
    mchk(4, 20, 20);
    mchk(6, 20, 20);
    fw_update_in <= 1'b0;
    power_low_in <= 1'b1;
    tick(4);
    mchk(4, 20, 10);
    mchk(8, 20, 10);
    power_low_in <= 1'b0;
    cfg_error_in <= 1'b1;
    tick(4);
    mchk(5, 20, 10);
    mchk(9, 20, 10);
    cfg_error_in <= 1'b0;
  endtask : t_unit
  // --------------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    tick(4);
    resetn_in <= 1'b1;
    tick(1);
    t_regs();
    t_can();
    t_lin();
    t_ctrl();
    t_unit();
    print_verdict();
  end
  // the whole sequence needs well under 2000 cycles
  initial begin
    #800000;
    mismatches++;
    print_verdict();
  end
endmodule : lsi_top_bench
